// File: hdl/adcc_dev.sv
// Functional notes
// - chain mode turns status pin into chain input
// - first converter regular, downstream ones chain mode
// - chain bits enter shift register behind own result
// - chain data appears after 16 or 24 clocks
// - host holds select low for whole chain
// - first word after select fall is own result
// - later words come from upstream converters
// - select toggled between words reloads own result
// - untriggered converter still sends previous result
// - no tag: 16 clocks, no trailing bits
// - chain with tag: 24 clocks per word, chain data after the five zeros
// - regular with tag: 24 clocks, five zeros
// - host serial clock rate set by HALF_CYC alone, same in every mode
// - power-on, software and pin resets supported
// - power-on reset gives defaults without commands
// - soft reset bit written 0 returns to 1
// - unused reset pin tied high
// - reset pin held low at least 25 ns
// - host waits 2 us after reset
// - first frame after reset sends all ones
// - tag bits give channel number in binary
// - serial output driven only while select low
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_dev (
    // system clock side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // conversion results
    input wire logic result_valid,
    input wire adcc_pkg::adcc_word_t result,
    input wire adcc_pkg::adcc_tag_t result_chan,
    // configuration writes
    input wire logic cfg_wr,
    input wire logic cfg_chain,
    input wire logic cfg_tag,
    input wire logic cfg_soft_reset,
    // configuration and status
    output logic chain_mode_select_bit,
    output logic channel_tag_enable_bit,
    output logic soft_reset_bit,
    output logic eoc_pending,
    // serial link
    adcc_if.dev link
);
    import adcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // synchronisers for pins entering the system clock domain

    // reset pin synchroniser
    logic rpin_s1;
    logic rpin_s2;
    // chip select synchroniser and edge history
    logic cs_s1;
    logic cs_s2;
    logic cs_s3;
    // any reset source active this cycle
    logic do_reset;
    // frame begins or ends, seen in the system domain
    logic frame_start;
    logic frame_end;

    // two flops for the reset pin, three for select
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            rpin_s1 <= 1'b1;
            rpin_s2 <= 1'b1;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
            cs_s3 <= 1'b1;
        end else if (ce) begin
            rpin_s1 <= link.rst_pin_n;
            rpin_s2 <= rpin_s1;
            cs_s1 <= link.cs_n;
            cs_s2 <= cs_s1;
            cs_s3 <= cs_s2;
        end
    end

    // power-on, pin or software reset
    assign do_reset = !rst_n || !rpin_s2 || !soft_reset_bit;
    assign frame_start = !cs_s2 && cs_s3;
    assign frame_end = cs_s2 && !cs_s3;

    ////////////////////////////////////////////////////////////////////////
    // configuration bits

    // soft reset bit: a written 0 lasts one cycle, then reads 1 again
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            soft_reset_bit <= `ADCC_SOFT_RST_IDLE;
        end else if (ce) begin
            if (!soft_reset_bit) begin
                soft_reset_bit <= `ADCC_SOFT_RST_IDLE;
            end else if (cfg_wr && !cfg_soft_reset) begin
                soft_reset_bit <= 1'b0;
            end
        end
    end

    // mode bits, back to defaults on every reset source
    always_ff @(posedge clk) begin
        if (do_reset) begin
            chain_mode_select_bit <= `ADCC_CHAIN_RST;
            channel_tag_enable_bit <= `ADCC_TAG_RST;
        end else if (ce && cfg_wr) begin
            chain_mode_select_bit <= cfg_chain;
            channel_tag_enable_bit <= cfg_tag;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result holding and status pin

    // latest result, kept even without a new trigger
    adcc_word_t pend_word;
    adcc_tag_t pend_chan;
    // result frozen for the link while a frame runs
    adcc_word_t hold_word;
    adcc_tag_t hold_chan;
    // first frame after a reset sends ones
    logic after_reset;
    // status pin drive level and enable
    logic int_level;
    logic int_drive;

    // capture each new result; no new result keeps the old one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_word <= '0;
            pend_chan <= '0;
        end else if (ce && result_valid) begin
            pend_word <= result;
            pend_chan <= result_chan;
        end
    end

    // copy into the link holding register only between frames
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hold_word <= '0;
            hold_chan <= '0;
        end else if (ce && cs_s2) begin
            hold_word <= pend_word;
            hold_chan <= pend_chan;
        end
    end

    // set by any reset, cleared when a frame ends; set wins
    always_ff @(posedge clk) begin
        if (do_reset) begin
            after_reset <= 1'b1;
        end else if (ce && frame_end) begin
            after_reset <= 1'b0;
        end
    end

    // end of conversion flag, cleared by a frame start; set wins
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            eoc_pending <= 1'b0;
        end else if (ce) begin
            if (result_valid) begin
                eoc_pending <= 1'b1;
            end else if (frame_start) begin
                eoc_pending <= 1'b0;
            end
        end
    end

    // status pin: active low end of conversion, released in chain mode
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            int_level <= 1'b1;
            int_drive <= 1'b1;
        end else if (ce) begin
            int_level <= !eoc_pending;
            int_drive <= !chain_mode_select_bit;
        end
    end

    assign link.int_o = int_level;
    assign link.int_oe = int_drive;

    ////////////////////////////////////////////////////////////////////////
    // word to load at the first serial edge, quasi-static during frames

    // load image and frame options handed to the link domain
    logic [`ADCC_SR_W-1:0] load_word;
    logic load_tag;
    logic load_chain;
    logic load_ones;

    // refreshed only while select is high, so stable during a frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            load_word <= `ADCC_ONES_WORD;
            load_tag <= 1'b0;
            load_chain <= 1'b0;
            load_ones <= 1'b1;
        end else if (ce && cs_s2) begin
            load_tag <= channel_tag_enable_bit;
            load_chain <= chain_mode_select_bit;
            load_ones <= after_reset;
            if (after_reset) begin
                load_word <= `ADCC_ONES_WORD;
            end else if (channel_tag_enable_bit) begin
                load_word <= {hold_word, hold_chan, {`ADCC_TAG_PAD{1'b0}}};
            end else begin
                load_word <= {hold_word, 8'h00};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // link domain: shift register on the falling serial clock edge

    // output shift register, msb drives the serial line
    logic [`ADCC_SR_W-1:0] shreg;
    logic [`ADCC_SR_W-1:0] next_shreg;
    // first edge of the frame still to come
    logic first_edge;
    // bit shifted in at bit 0, or at bit 8 when tagging is off
    logic chain_bit;

    // incoming bit: ones after reset, upstream data in chain mode
    always_comb begin
        if (load_ones) begin
            chain_bit = 1'b1;
        end else if (load_chain) begin
            chain_bit = link.int_i;
        end else begin
            chain_bit = 1'b0;
        end
        next_shreg = {shreg[`ADCC_SR_W-2:0], 1'b0};
        if (load_tag) begin
            next_shreg[0] = chain_bit;
        end else begin
            next_shreg[`ADCC_CHAIN_LSB_NOTAG] = chain_bit;
        end
    end

    // select high clears the frame; first edge loads own result
    always_ff @(negedge link.sclk or posedge link.cs_n) begin
        if (link.cs_n) begin
            first_edge <= 1'b1;
            shreg <= '0;
        end else if (first_edge) begin
            first_edge <= 1'b0;
            shreg <= load_word;
        end else begin
            shreg <= next_shreg;
        end
    end

    // line follows select directly so its rising edge releases it
    assign link.sdo_o = shreg[`ADCC_SR_W-1];
    assign link.sdo_oe = !link.cs_n;
endmodule

// File: hdl/adcc_consts.svh
`ifndef ADCC_CONSTS_SVH
`define ADCC_CONSTS_SVH
// system clock period in ns
`define ADCC_CLK_NS 4
// result word and frame layout
`define ADCC_WORD_BITS 16
`define ADCC_TAG_BITS 3
`define ADCC_TAG_PAD 5
`define ADCC_TAG_WORD_BITS 24
`define ADCC_SR_W 24
// bit of the shift register that takes the chain bit when tagging is off
`define ADCC_CHAIN_LSB_NOTAG 8
// value driven for a whole frame after any reset
`define ADCC_ONES_WORD 24'hFFFFFF
// reset defaults of the configuration bits
`define ADCC_CHAIN_RST 1'b0
`define ADCC_TAG_RST 1'b0
`define ADCC_SOFT_RST_IDLE 1'b1
// least low time of the reset pin
`define ADCC_RST_PULSE_NS 25
`define ADCC_RST_CYC ((`ADCC_RST_PULSE_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
// least wait after a reset before the first frame
`define ADCC_RECOV_NS 2000
`define ADCC_RECOV_CYC ((`ADCC_RECOV_NS + `ADCC_CLK_NS - 1) / `ADCC_CLK_NS)
// default half period of the serial clock in system clocks
`define ADCC_HALF_CYC 8
`endif

// File: hdl/adcc_pkg.sv
package adcc_pkg;
    // one conversion result
    typedef logic [15:0] adcc_word_t;
    // source channel tag
    typedef logic [2:0] adcc_tag_t;
    // one received frame word, right adjusted
    typedef logic [23:0] adcc_frame_t;
    // host sequencer states
    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_RST = 3'b001,
        H_WAIT = 3'b010,
        H_SETUP = 3'b011,
        H_LOW = 3'b100,
        H_HIGH = 3'b101,
        H_END = 3'b110
    } adcc_hstate_t;
endpackage

// File: hdl/adcc_if.sv
`timescale 1ns/1ps
interface adcc_if;
    // serial clock, idles high, made by the host
    logic sclk;
    // frame chip select, active low
    logic cs_n;
    // reset pin, active low
    logic rst_pin_n;
    // serial data from the device
    logic sdo_o;
    logic sdo_oe;
    // resolved serial data as the host sees it
    logic sdo;
    // status pin; in chain mode an input from the upstream converter
    logic int_o;
    logic int_oe;
    logic int_i;
    // undriven serial line reads low here
    assign sdo = sdo_oe ? sdo_o : 1'b0;
    modport dev (
        input sclk, cs_n, rst_pin_n, int_i,
        output sdo_o, sdo_oe, int_o, int_oe
    );
    modport host (
        input sdo,
        output sclk, cs_n, rst_pin_n
    );
endinterface

// File: hdl/adcc_host.sv
`timescale 1ns/1ps
`include "adcc_consts.svh"
module adcc_host #(
    parameter int HALF_CYC = `ADCC_HALF_CYC
) (
    // system clock side
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // requests
    input wire logic start,
    input wire logic [3:0] num_words,
    input wire logic [4:0] word_bits,
    input wire logic reset_req,
    // answers
    output logic busy,
    output adcc_pkg::adcc_frame_t rx_word,
    output logic rx_valid,
    // serial link
    adcc_if.host link
);
    import adcc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    // sequencer state and timer
    adcc_hstate_t state;
    logic [9:0] tmr;
    // bit and word counters, latched frame shape
    logic [4:0] bitc;
    logic [4:0] bits;
    logic [3:0] wc;
    logic [3:0] nw;
    // serial input synchroniser and receive shifter
    logic sdo_s1;
    logic sdo_s2;
    adcc_frame_t rxsh;
    adcc_frame_t next_rxsh;
    // pin registers
    logic sclk_q;
    logic cs_q;
    logic rpin_q;

    assign next_rxsh = {rxsh[22:0], sdo_s2};
    assign link.sclk = sclk_q;
    assign link.cs_n = cs_q;
    assign link.rst_pin_n = rpin_q;

    ////////////////////////////////////////////////////////////////////////
    // serial data synchroniser
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sdo_s1 <= 1'b0;
            sdo_s2 <= 1'b0;
        end else if (ce) begin
            sdo_s1 <= link.sdo;
            sdo_s2 <= sdo_s1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer: reset pulse, recovery, frames of words
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // power-on counts as a reset: wait before the first frame
            state <= H_WAIT;
            tmr <= 10'(`ADCC_RECOV_CYC - 1);
            sclk_q <= 1'b1;
            cs_q <= 1'b1;
            rpin_q <= 1'b1;
            busy <= 1'b1;
            bitc <= '0;
            bits <= 5'(`ADCC_WORD_BITS);
            wc <= '0;
            nw <= '0;
            rxsh <= '0;
            rx_word <= '0;
            rx_valid <= 1'b0;
        end else if (ce) begin
            rx_valid <= 1'b0;
            case (state)
                H_IDLE: begin
                    // reset request first, then a frame
                    if (reset_req) begin
                        state <= H_RST;
                        rpin_q <= 1'b0;
                        tmr <= 10'(`ADCC_RST_CYC - 1);
                        busy <= 1'b1;
                    end else if (start) begin
                        state <= H_SETUP;
                        cs_q <= 1'b0;
                        tmr <= 10'(HALF_CYC - 1);
                        bits <= word_bits;
                        nw <= num_words;
                        bitc <= '0;
                        wc <= '0;
                        busy <= 1'b1;
                    end
                end
                H_RST: begin
                    // reset pin low for its least time
                    if (tmr == '0) begin
                        state <= H_WAIT;
                        rpin_q <= 1'b1;
                        tmr <= 10'(`ADCC_RECOV_CYC - 1);
                    end else begin
                        tmr <= tmr - 10'h001;
                    end
                end
                H_WAIT: begin
                    // recovery time before any frame
                    if (tmr == '0) begin
                        state <= H_IDLE;
                        busy <= 1'b0;
                    end else begin
                        tmr <= tmr - 10'h001;
                    end
                end
                H_SETUP, H_HIGH: begin
                    // end of high phase: next bit or close the frame
                    if (tmr != '0) begin
                        tmr <= tmr - 10'h001;
                    end else if (state == H_HIGH && wc == nw) begin
                        state <= H_END;
                        cs_q <= 1'b1;
                        tmr <= 10'(HALF_CYC - 1);
                    end else begin
                        state <= H_LOW;
                        sclk_q <= 1'b0;
                        tmr <= 10'(HALF_CYC - 1);
                    end
                end
                H_LOW: begin
                    // rising edge: sample the bit the device set on the fall
                    if (tmr == '0) begin
                        state <= H_HIGH;
                        sclk_q <= 1'b1;
                        tmr <= 10'(HALF_CYC - 1);
                        if (bitc == bits - 5'h01) begin
                            // word complete: hand it over, next word starts from zero
                            rx_word <= next_rxsh;
                            rx_valid <= 1'b1;
                            rxsh <= '0;
                            bitc <= '0;
                            wc <= wc + 4'h1;
                        end else begin
                            rxsh <= next_rxsh;
                            bitc <= bitc + 5'h01;
                        end
                    end else begin
                        tmr <= tmr - 10'h001;
                    end
                end
                H_END: begin
                    // select high gap before the next request
                    if (tmr == '0) begin
                        state <= H_IDLE;
                        busy <= 1'b0;
                    end else begin
                        tmr <= tmr - 10'h001;
                    end
                end
                default: begin
                    state <= H_IDLE;
                end
            endcase
        end
    end
endmodule

// File: tb/adcc_link_sva.sv
`timescale 1ns/1ps
module adcc_link_sva (
    // system clock domain
    input wire logic clk,
    input wire logic rst_n,
    input wire logic soft_reset_bit,
    // link signals
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic rst_pin_n,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    input wire logic int_o,
    input wire logic int_oe,
    input wire logic int_i
);
    logic sclk_q; // serial clock one cycle ago
    logic cs_q; // select one cycle ago
    logic ones_pend; // next frame must read all ones
    logic [8:0] cnt; // serial clock rises so far in the frame
    logic [23:0] hist; // chain input bits, newest in bit 0
    wire logic rise; // serial clock rose since last cycle
    assign rise = sclk && !sclk_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////
    // edge history of the link clock and select
    always_ff @(posedge clk) begin
        sclk_q <= sclk;
        cs_q <= cs_n;
    end
    // bit counter and chain input history within a frame
    always_ff @(posedge clk) begin
        if (cs_n) begin
            cnt <= 9'h000;
        end else if (rise) begin
            cnt <= cnt + 9'h001;
            hist <= {hist[22:0], int_i};
        end
    end
    // any reset arms the all-ones frame, a finished frame clears it
    always_ff @(posedge clk) begin
        if (!rst_n || !rst_pin_n || !soft_reset_bit) begin
            ones_pend <= 1'b1;
        end else if (cs_n && !cs_q) begin
            ones_pend <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////
    chk_oe_follows_cs:
        assert property (sdo_oe == !cs_n) else $error("sdo enable differs from select");
    chk_oe_on_fall:
        assert property ($fell(cs_n) |-> sdo_oe ##1 sdo_oe) else $error("sdo not driven");
    chk_release_rise:
        assert property ($rose(cs_n) |-> !sdo_oe) else $error("sdo not released");
    chk_shift_on_fall:
        assert property ((!cs_n && !$past(cs_n) && $changed(sdo_o)) |-> $fell(sclk))
        else $error("sdo moved off a falling serial clock");
    chk_ones_after_reset:
        assert property ((ones_pend && !cs_n && rise) |-> sdo_o)
        else $error("zero bit in first frame after reset");
    chk_chain_delay:
        assert property ((!int_oe && !cs_n && rise && !ones_pend && cnt >= 9'h018)
            |-> (sdo_o == hist[15] || sdo_o == hist[23]))
        else $error("chain bit not passed with its delay");
    chk_regular_trail:
        assert property ((int_oe && !cs_n && rise && !ones_pend && cnt >= 9'h013) |-> !sdo_o)
        else $error("trailing bit not zero");
    chk_int_defaults:
        assert property (!$past(rst_n) |-> (int_oe && int_o))
        else $error("status pin not at default after reset");
endmodule

// File: tb/adc_daisy_chain_readout_reset_tb.sv
`timescale 1ns/1ps
module adc_daisy_chain_readout_reset_tb;
    import adcc_pkg::*;
    localparam int HALF = 4; // short serial half period
    localparam int LIMIT = 30000; // cycle ceiling of the run
    // clock, reset and enable
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    // converter stimulus; index 1 sits on the host link, index 0 upstream
    logic [1:0] rv = 2'h0, cw = 2'h0, cc = 2'h0, ct = 2'h0, cs = 2'h3;
    adcc_word_t res[2];
    adcc_tag_t rch[2];
    wire [1:0] ch_o, tg_o, sr_o, eoc;
    // host requests and answers
    logic start = 1'b0;
    logic [3:0] nw = 4'h1;
    logic [4:0] wb = 5'h10;
    logic rreq = 1'b0;
    logic busy, rx_valid;
    adcc_frame_t rx_word;
    int err_total = 0;
    int n_checks = 0;
    int cyc = 0;
    int t, r;
    logic [23:0] e;
    // reference model state per converter
    int m_res[2], m_ch[2], m_chain[2], m_tag[2], m_ones[2];
    ////////////////////////////////////////////////////////////////
    adcc_if la();
    adcc_if lb();
    // upstream converter shares clock, select and reset pin
    assign lb.sclk = la.sclk;
    assign lb.cs_n = la.cs_n;
    assign lb.rst_pin_n = la.rst_pin_n;
    // status pins: own drive wins, else upstream data or pull-up
    assign la.int_i = la.int_oe ? la.int_o : lb.sdo;
    assign lb.int_i = lb.int_oe ? lb.int_o : 1'b1;
    adcc_host #(.HALF_CYC(HALF)) adcc_host_i (.clk(clk), .rst_n(rst_n), .ce(ce),
        .start(start), .num_words(nw), .word_bits(wb), .reset_req(rreq), .busy(busy),
        .rx_word(rx_word), .rx_valid(rx_valid), .link(la));
    adcc_dev adcc_dev_i (.clk(clk), .rst_n(rst_n), .ce(ce), .result_valid(rv[1]),
        .result(res[1]), .result_chan(rch[1]), .cfg_wr(cw[1]), .cfg_chain(cc[1]),
        .cfg_tag(ct[1]), .cfg_soft_reset(cs[1]), .chain_mode_select_bit(ch_o[1]),
        .channel_tag_enable_bit(tg_o[1]), .soft_reset_bit(sr_o[1]), .eoc_pending(eoc[1]),
        .link(la));
    adcc_dev adcc_dev_i2 (.clk(clk), .rst_n(rst_n), .ce(ce), .result_valid(rv[0]),
        .result(res[0]), .result_chan(rch[0]), .cfg_wr(cw[0]), .cfg_chain(cc[0]),
        .cfg_tag(ct[0]), .cfg_soft_reset(cs[0]), .chain_mode_select_bit(ch_o[0]),
        .channel_tag_enable_bit(tg_o[0]), .soft_reset_bit(sr_o[0]), .eoc_pending(eoc[0]),
        .link(lb));
    adcc_link_sva adcc_link_sva_i (.clk(clk), .rst_n(rst_n), .soft_reset_bit(sr_o[1]),
        .sclk(la.sclk), .cs_n(la.cs_n), .rst_pin_n(la.rst_pin_n), .sdo_o(la.sdo_o),
        .sdo_oe(la.sdo_oe), .int_o(la.int_o), .int_oe(la.int_oe), .int_i(la.int_i));
    ////////////////////////////////////////////////////////////////
    // system clock
    always #2 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            err_total++;
            wrap_up();
        end
    end
    // verdict and end of run
    task wrap_up();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one comparison
    task automatic cmp(string nm, logic [23:0] got, logic [23:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // bit k of the stream leaving converter d
    function automatic bit exp_bit(int d, int k);
        int w;
        w = m_tag[d] ? 24 : 16;
        if (m_ones[d] != 0) return 1'b1;
        if (k < 16) return m_res[d][15 - k];
        if (k < w) return (k < 19) ? m_ch[d][18 - k] : 1'b0;
        if (m_chain[d] != 0 && d > 0) return exp_bit(d - 1, k - w);
        return 1'b0;
    endfunction
    // wait until the host is idle
    task idle();
        t = 0;
        while (busy !== 1'b0 && t < 1000) begin
            @(posedge clk);
            t++;
        end
        if (t >= 1000) begin
            err_total++;
            wrap_up();
        end
    endtask
    // hand a random result with channel c to converter d
    task give(int d, int c);
        r = $urandom;
        @(posedge clk);
        rv[d] <= 1'b1;
        res[d] <= r[15:0];
        rch[d] <= c[2:0];
        m_res[d] = r & 32'hFFFF;
        m_ch[d] = c;
        @(posedge clk);
        rv[d] <= 1'b0;
        @(posedge clk);
        cmp("eoc_pending", eoc[d], 1'b1);
        if (d == 1) cmp("int_oe", la.int_oe, m_chain[1] == 0);
    endtask
    // write the configuration of converter d
    task cfg(int d, int ch, int tg, int sr);
        @(posedge clk);
        cw[d] <= 1'b1;
        cc[d] <= ch[0];
        ct[d] <= tg[0];
        cs[d] <= sr[0];
        @(posedge clk);
        cw[d] <= 1'b0;
        m_chain[d] = sr ? ch : 0;
        m_tag[d] = sr ? tg : 0;
        if (sr == 0) m_ones[d] = 1;
        @(posedge clk);
        cmp("soft_reset_bit", sr_o[d], sr[0]);
        @(posedge clk);
        cmp("soft_reset_bit", sr_o[d], 1'b1);
        cmp("chain_bit", ch_o[d], m_chain[d][0]);
        cmp("tag_bit", tg_o[d], m_tag[d][0]);
    endtask
    // one continuous-select frame of n words of w bits
    task frame(int n, int w);
        @(posedge clk);
        start <= 1'b1;
        nw <= n[3:0];
        wb <= w[4:0];
        @(posedge clk);
        start <= 1'b0;
        for (int i = 0; i < n; i++) begin
            t = 0;
            do begin
                @(posedge clk);
                t++;
            end while (rx_valid !== 1'b1 && t < 2000);
            if (t >= 2000) begin
                err_total++;
                wrap_up();
            end
            e = 24'h000000;
            for (int j = 0; j < w; j++) e = {e[22:0], exp_bit(1, i * w + j)};
            cmp("rx_word", rx_word, e);
        end
        idle();
        m_ones = '{0, 0};
    endtask
    ////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        res = '{16'h0000, 16'h0000};
        rch = '{3'h0, 3'h0};
        m_res = '{0, 0};
        m_ch = '{0, 0};
        m_chain = '{0, 0};
        m_tag = '{0, 0};
        m_ones = '{1, 1};
        void'($urandom(32'h6e4e8c77));
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        idle();
        cmp("chain_bit", ch_o[1], 1'b0);
        cmp("tag_bit", tg_o[1], 1'b0);
        cmp("soft_reset_bit", sr_o[1], 1'b1);
        // a write offered only while the enable is low must not land
        @(posedge clk);
        ce <= 1'b0;
        cw[1] <= 1'b1;
        cc[1] <= 1'b1;
        repeat (4) @(posedge clk);
        ce <= 1'b1;
        cw[1] <= 1'b0;
        @(posedge clk);
        @(posedge clk);
        cmp("chain_bit", ch_o[1], 1'b0);
        frame(1, 16);
        give(1, 5);
        frame(2, 16);
        cfg(1, 0, 1, 1);
        for (int c = 0; c < 8; c++) begin
            give(1, c);
            frame(1, 24);
        end
        cfg(1, 1, 0, 1);
        give(0, 1);
        give(1, 2);
        frame(3, 16);
        cfg(0, 0, 1, 1);
        cfg(1, 1, 1, 1);
        give(0, 3);
        give(1, 4);
        frame(2, 24);
        frame(1, 24);
        frame(1, 24);
        give(0, 6);
        frame(2, 24);
        cfg(1, 1, 1, 0);
        repeat (500) @(posedge clk);
        frame(1, 16);
        cfg(1, 1, 0, 1);
        @(posedge clk);
        rreq <= 1'b1;
        @(posedge clk);
        rreq <= 1'b0;
        @(posedge clk);
        idle();
        m_chain = '{0, 0};
        m_tag = '{0, 0};
        m_ones = '{1, 1};
        cmp("chain_bit", ch_o[1], 1'b0);
        frame(1, 16);
        frame(1, 16);
        wrap_up();
    end
endmodule
